// file: hdl/rpo_pkg.sv
// package: constants, types and lookup tables of the retransmit pulse output
// Summary of operation
// - pass-through origin copies input one or input two synchronously onto the output switch.
// - count-derived origin makes pulses from total increments, divided, with fixed width.
// - derived mode: indicator follows closed switch; pass-through mode: indicator always lit.
// - count-derived pulses are produced only while counting function is input sum.
// - pulses that cannot go out in real time are counted, then sent back to back.
// - total reset or power loss discards every pending output pulse.
// - output enable suppresses or allows the output, leaving other settings untouched.
// - divisor selectable among decade values one to ten thousand.
// - pulse width is one of eleven millisecond values up to half a second.
// - an active pulse closes the isolated switch joining the two output terminals.
// - over one minute without a button in the menu returns to display, discarding changes.
// - quadrature mode decodes direction and amount from two quarter-cycle offset inputs.
package rpo_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 100; // 0.1 ms grain, finest pulse width
    localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
    localparam int MENU_TIMEOUT_S = 60;
    localparam int MENU_TIMEOUT_TICKS = MENU_TIMEOUT_S * 1_000_000 / TICK_US;

    // ------------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------------
    localparam int DIV_W = 14;
    localparam int LEN_W = 13;
    localparam int PEND_W = 16;
    localparam int IDLE_W = 20;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RPO_PASS_FIRST = 2'h0,
        RPO_PASS_SECOND = 2'h1,
        RPO_COUNT_DERIVED = 2'h2
    } rpo_origin_t;

    typedef enum logic [1:0] {
        RPO_FN_SUM = 2'h0,
        RPO_FN_DIFF = 2'h1,
        RPO_FN_QUAD = 2'h2
    } rpo_count_fn_t;

    typedef enum logic [1:0] {
        RPO_EMIT_IDLE = 2'h0,
        RPO_EMIT_HIGH = 2'h1,
        RPO_EMIT_GAP = 2'h3
    } rpo_emit_t;

    typedef struct packed {
        rpo_emit_t emit;
        logic [DIV_W-1:0] div_cnt;
        logic [PEND_W-1:0] pending;
        logic [LEN_W-1:0] len_cnt;
        logic switch_closed;
        logic indicator;
        logic a_prev;
        logic b_prev;
        logic quad_step;
        logic quad_up;
        logic menu_mode;
        logic [IDLE_W-1:0] idle_cnt;
        logic menu_timeout;
    } rpo_state_t;

    localparam rpo_state_t RPO_STATE_RESET = '0;

    // ------------------------------------------------------------------
    // lookup tables
    // ------------------------------------------------------------------
    // decade divisor; codes above four clamp to the largest
    function automatic logic [DIV_W-1:0] rpo_divisor(input logic [2:0] sel);
        case (sel)
            3'h0: return 14'h0001;
            3'h1: return 14'h000A;
            3'h2: return 14'h0064;
            3'h3: return 14'h03E8;
            default: return 14'h2710;
        endcase
    endfunction : rpo_divisor

    // pulse width in 0.1 ms ticks: 0.1 0.5 1 2.5 5 10 25 50 100 250 500 ms
    function automatic logic [LEN_W-1:0] rpo_width_ticks(input logic [3:0] sel);
        case (sel)
            4'h0: return 13'h0001;
            4'h1: return 13'h0005;
            4'h2: return 13'h000A;
            4'h3: return 13'h0019;
            4'h4: return 13'h0032;
            4'h5: return 13'h0064;
            4'h6: return 13'h00FA;
            4'h7: return 13'h01F4;
            4'h8: return 13'h03E8;
            4'h9: return 13'h09C4;
            default: return 13'h1388;
        endcase
    endfunction : rpo_width_ticks

endpackage : rpo_pkg

// file: hdl/rpo_tick_div.sv
// module: clock divider giving a one-cycle enable pulse every PERIOD cycles
module rpo_tick_div #(
    parameter int PERIOD = 1000
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic restart_i,
    output logic tick_o
);
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    localparam logic [CW-1:0] FIRST = (PERIOD > 1) ? CW'(1) : CW'(0);

    logic [CW-1:0] cnt_r;

    // restart counts its own cycle, so a phase lasts exactly whole periods, not one cycle more
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
            tick_o <= 1'b0;
        end else if (restart_i) begin
            cnt_r <= FIRST;
            tick_o <= (PERIOD == 1);
        end else begin
            tick_o <= (cnt_r == LAST);
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
        end
    end
endmodule : rpo_tick_div

// file: hdl/rpo_retransmit.sv
// module: retransmit pulse output with pass-through, count-derived queueing and menu timeout
module rpo_retransmit #(
    parameter logic [rpo_pkg::IDLE_W-1:0] MENU_TIMEOUT_TICKS = rpo_pkg::IDLE_W'(rpo_pkg::MENU_TIMEOUT_TICKS),
    parameter int TICK_CYCLES = rpo_pkg::TICK_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic input_a_i,
    input wire logic input_b_i,
    input wire logic total_inc_i,
    input wire logic total_reset_i,
    input wire rpo_pkg::rpo_count_fn_t count_function_i,
    input wire logic pulse_output_on_i,
    input wire rpo_pkg::rpo_origin_t pulse_origin_select_i,
    input wire logic [2:0] rate_divisor_i,
    input wire logic [3:0] pulse_length_select_i,
    input wire logic prog_button_i,
    input wire logic enter_button_i,
    input wire logic up_button_i,
    input wire logic down_button_i,
    input wire logic menu_exit_i,
    output logic pulse_switch_closed_o,
    output logic retransmit_indicator_o,
    output logic quad_step_o,
    output logic quad_up_o,
    output logic config_mode_o,
    output logic menu_timeout_o
);
    import rpo_pkg::*;

    // ------------------------------------------------------------------
    // state and timing grains
    // ------------------------------------------------------------------
    rpo_state_t st_r;
    rpo_state_t st_nxt;
    logic pulse_tick;
    logic menu_tick;
    logic phase_restart;

    // pulse grain restarts on every phase change so widths are exact
    rpo_tick_div #(
        .PERIOD(TICK_CYCLES)
    ) u_pulse_tick (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .restart_i(phase_restart),
        .tick_o(pulse_tick)
    );

    rpo_tick_div #(
        .PERIOD(TICK_CYCLES)
    ) u_menu_tick (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .restart_i(1'b0),
        .tick_o(menu_tick)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic derived;
        logic inc;
        logic take;
        logic emit_end;
        logic any_button;
        logic a_chg;
        logic b_chg;
        logic [DIV_W-1:0] div_last;
        logic [LEN_W-1:0] width;
        derived = 1'b0;
        inc = 1'b0;
        take = 1'b0;
        emit_end = 1'b0;
        any_button = 1'b0;
        a_chg = 1'b0;
        b_chg = 1'b0;
        div_last = '0;
        width = '0;
        st_nxt = st_r;

        derived = (pulse_origin_select_i == RPO_COUNT_DERIVED);
        div_last = rpo_divisor(rate_divisor_i) - 1'b1;
        width = rpo_width_ticks(pulse_length_select_i);

        // ----------------------------------------------------------
        // divisor: one queued pulse per divisor increments
        // ----------------------------------------------------------
        inc = derived && total_inc_i && (count_function_i == RPO_FN_SUM);
        if (inc) begin
            st_nxt.div_cnt = (st_r.div_cnt >= div_last) ? '0 : st_r.div_cnt + 1'b1;
        end

        // ----------------------------------------------------------
        // emitter: high for width, gap for width, back to back
        // ----------------------------------------------------------
        emit_end = pulse_tick && (st_r.len_cnt == width - 1'b1);
        if (pulse_tick) begin
            st_nxt.len_cnt = st_r.len_cnt + 1'b1;
        end
        unique case (st_r.emit)
            RPO_EMIT_IDLE: begin
                if (st_r.pending != '0) begin
                    take = 1'b1;
                    st_nxt.emit = RPO_EMIT_HIGH;
                    st_nxt.len_cnt = '0;
                end
            end
            RPO_EMIT_HIGH: begin
                if (emit_end) begin
                    st_nxt.emit = RPO_EMIT_GAP;
                    st_nxt.len_cnt = '0;
                end
            end
            RPO_EMIT_GAP: begin
                if (emit_end) begin
                    // queued pulses leave at the fastest rate the width allows
                    if (st_r.pending != '0) begin
                        take = 1'b1;
                        st_nxt.emit = RPO_EMIT_HIGH;
                    end else begin
                        st_nxt.emit = RPO_EMIT_IDLE;
                    end
                    st_nxt.len_cnt = '0;
                end
            end
            default: begin
                st_nxt.emit = RPO_EMIT_IDLE;
                st_nxt.len_cnt = '0;
            end
        endcase

        // queue saturates rather than wrap; a wrap would lose the whole backlog
        if (inc && st_r.div_cnt >= div_last && !take && st_r.pending != '1) begin
            st_nxt.pending = st_r.pending + 1'b1;
        end else if (take && !(inc && st_r.div_cnt >= div_last)) begin
            st_nxt.pending = st_r.pending - 1'b1;
        end

        // pass-through ignores divisor and width entirely
        if (!derived) begin
            st_nxt.emit = RPO_EMIT_IDLE;
            st_nxt.pending = '0;
            st_nxt.div_cnt = '0;
            st_nxt.len_cnt = '0;
        end

        // total reset drops the backlog; a pulse already out completes
        if (total_reset_i) begin
            st_nxt.pending = '0;
            st_nxt.div_cnt = '0;
        end

        // ----------------------------------------------------------
        // output switch and indicator
        // ----------------------------------------------------------
        unique case (pulse_origin_select_i)
            RPO_PASS_FIRST: st_nxt.switch_closed = pulse_output_on_i && input_a_i;
            RPO_PASS_SECOND: st_nxt.switch_closed = pulse_output_on_i && input_b_i;
            RPO_COUNT_DERIVED: st_nxt.switch_closed = pulse_output_on_i && (st_nxt.emit == RPO_EMIT_HIGH);
            default: st_nxt.switch_closed = 1'b0;
        endcase
        st_nxt.indicator = derived ? st_nxt.switch_closed : 1'b1;

        // ----------------------------------------------------------
        // quadrature decode, four counts per input cycle
        // ----------------------------------------------------------
        a_chg = input_a_i ^ st_r.a_prev;
        b_chg = input_b_i ^ st_r.b_prev;
        st_nxt.a_prev = input_a_i;
        st_nxt.b_prev = input_b_i;
        st_nxt.quad_step = (count_function_i == RPO_FN_QUAD) && (a_chg ^ b_chg);
        if (count_function_i == RPO_FN_QUAD && (a_chg ^ b_chg)) begin
            // a step with input one leading reads as up
            st_nxt.quad_up = st_r.a_prev ~^ input_b_i;
        end

        // ----------------------------------------------------------
        // configuration menu and inactivity timeout
        // ----------------------------------------------------------
        any_button = prog_button_i || enter_button_i || up_button_i || down_button_i;
        st_nxt.menu_timeout = 1'b0;
        if (!st_r.menu_mode) begin
            st_nxt.idle_cnt = '0;
            if (prog_button_i && enter_button_i) begin
                st_nxt.menu_mode = 1'b1;
            end
        end else if (menu_exit_i) begin
            st_nxt.menu_mode = 1'b0;
            st_nxt.idle_cnt = '0;
        end else if (any_button) begin
            st_nxt.idle_cnt = '0;
        end else if (menu_tick) begin
            if (st_r.idle_cnt >= MENU_TIMEOUT_TICKS - 1'b1) begin
                st_nxt.menu_mode = 1'b0;
                st_nxt.menu_timeout = 1'b1;
                st_nxt.idle_cnt = '0;
            end else begin
                st_nxt.idle_cnt = st_r.idle_cnt + 1'b1;
            end
        end
    end

    assign phase_restart = (st_nxt.emit != st_r.emit);

    // ------------------------------------------------------------------
    // state register; power loss empties the queue as reset does
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= RPO_STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign pulse_switch_closed_o = st_r.switch_closed;
    assign retransmit_indicator_o = st_r.indicator;
    assign quad_step_o = st_r.quad_step;
    assign quad_up_o = st_r.quad_up;
    assign config_mode_o = st_r.menu_mode;
    assign menu_timeout_o = st_r.menu_timeout;

endmodule : rpo_retransmit

// file: verification/rpo_retransmit_properties.sv
// checker: concurrent properties of the retransmit pulse output
module rpo_retransmit_properties #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic input_a_i,
    input wire logic input_b_i,
    input wire rpo_pkg::rpo_count_fn_t count_function_i,
    input wire logic pulse_output_on_i,
    input wire rpo_pkg::rpo_origin_t pulse_origin_select_i,
    input wire logic [3:0] pulse_length_select_i,
    input wire logic prog_button_i,
    input wire logic enter_button_i,
    input wire logic pulse_switch_closed_o,
    input wire logic retransmit_indicator_o,
    input wire logic quad_step_o,
    input wire logic quad_up_o,
    input wire logic config_mode_o,
    input wire logic menu_timeout_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import rpo_pkg::*;
    // ------------------------------------------------------------------
    // helper: lengths of the current high and low runs of the switch
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] hi;
        logic [15:0] lo;
    } rpo_chk_cnt_t;
    rpo_chk_cnt_t cnt_r;
    rpo_chk_cnt_t cnt_nxt;
    logic der;
    logic sw;
    assign der = pulse_origin_select_i == RPO_COUNT_DERIVED;
    assign sw = pulse_switch_closed_o;
    always_comb begin
        cnt_nxt = cnt_r;
        cnt_nxt.hi = sw ? cnt_r.hi + 16'h1 : 16'h0;
        // saturate so a long idle stretch never wraps into a short gap
        cnt_nxt.lo = sw ? 16'h0 : (cnt_r.lo == 16'hFFFF ? cnt_r.lo : cnt_r.lo + 16'h1);
    end
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    a_pass_copy: assert property (pulse_origin_select_i inside {RPO_PASS_FIRST, RPO_PASS_SECOND} && pulse_output_on_i
        |=> sw == $past(pulse_origin_select_i == RPO_PASS_FIRST ? input_a_i : input_b_i)) else $error("copy wrong");
    a_off_quiet: assert property (!pulse_output_on_i |=> !sw)
        else $error("switch closed while disabled");
    a_ind_lit: assert property (!der |=> retransmit_indicator_o)
        else $error("indicator dark in pass-through");
    a_ind_follow: assert property (der |=> retransmit_indicator_o == sw)
        else $error("indicator not following switch");
    a_pulse_len: assert property ($fell(sw) && der && $past(der, 2) && pulse_output_on_i
        && pulse_length_select_i == 4'h0 |-> cnt_r.hi == TICK_CYCLES) else $error("pulse length wrong");
    a_gap_len: assert property ($rose(sw) && der && pulse_length_select_i == 4'h0
        |-> cnt_r.lo >= TICK_CYCLES) else $error("gap too short");
    a_menu_enter: assert property (!config_mode_o && prog_button_i && enter_button_i |=> config_mode_o)
        else $error("menu not entered");
    a_timeout_exit: assert property (menu_timeout_o |-> $past(config_mode_o) && !config_mode_o ##1 !menu_timeout_o)
        else $error("timeout pulse wrong");
    a_quad_dir: assert property (count_function_i == RPO_FN_QUAD && ((input_a_i != $past(input_a_i)) ^
        (input_b_i != $past(input_b_i))) |=> quad_step_o && quad_up_o == !($past(input_a_i, 2) ^ $past(input_b_i)))
        else $error("quadrature step wrong");
    c_derived_pulse: cover property ($rose(sw) && der);
    c_timeout: cover property (menu_timeout_o);
    c_quad: cover property (quad_step_o);
endmodule : rpo_retransmit_properties

bind rpo_retransmit rpo_retransmit_properties #(.TICK_CYCLES(TICK_CYCLES)) u_rpo_retransmit_properties (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .input_a_i(input_a_i), .input_b_i(input_b_i),
    .count_function_i(count_function_i), .pulse_output_on_i(pulse_output_on_i),
    .pulse_origin_select_i(pulse_origin_select_i), .pulse_length_select_i(pulse_length_select_i),
    .prog_button_i(prog_button_i), .enter_button_i(enter_button_i), .pulse_switch_closed_o(pulse_switch_closed_o),
    .retransmit_indicator_o(retransmit_indicator_o), .quad_step_o(quad_step_o), .quad_up_o(quad_up_o),
    .config_mode_o(config_mode_o), .menu_timeout_o(menu_timeout_o)
);

// file: verification/rpo_remote_counter.sv
// model: remote counter behind a pulled-up open-collector pulse input
module rpo_remote_counter (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic switch_closed_i,
    output logic line_o,
    output int pulse_count_o,
    output int last_len_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int run;
    // closed switch joins the terminals and pulls the line low; open lets the pull-up win
    assign line_o = ~switch_closed_i;
    always @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run <= 0;
            pulse_count_o <= 0;
            last_len_o <= 0;
        end else if (!line_o) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulse_count_o <= pulse_count_o + 1;
            last_len_o <= run;
            run <= 0;
        end
    end
endmodule : rpo_remote_counter

// file: verification/rpo_retransmit_tb_top.sv
// testbench: directed scenarios for the retransmit pulse output
module rpo_retransmit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rpo_pkg::*;
    localparam int TK = 4;
    logic sys_clk_i = 1'b0, reset_n_i = 1'b0, input_a_i = 1'b0, input_b_i = 1'b0, total_inc_i = 1'b0;
    logic total_reset_i = 1'b0, pulse_output_on_i = 1'b1, prog_button_i = 1'b0, enter_button_i = 1'b0;
    logic up_button_i = 1'b0, down_button_i = 1'b0, menu_exit_i = 1'b0, line;
    rpo_count_fn_t count_function_i = RPO_FN_SUM;
    rpo_origin_t pulse_origin_select_i = RPO_PASS_FIRST;
    logic [2:0] rate_divisor_i = 3'h0;
    logic [3:0] pulse_length_select_i = 4'h0;
    logic pulse_switch_closed_o, retransmit_indicator_o, quad_step_o, quad_up_o, config_mode_o, menu_timeout_o;
    int fail_count = 0, checks = 0, cycles = 0, pulse_count, last_len;
    int divs [5] = '{1, 10, 100, 1000, 10000};
    int ticks [11] = '{1, 5, 10, 25, 50, 100, 250, 500, 1000, 2500, 5000};
    rpo_retransmit #(.MENU_TIMEOUT_TICKS(20'h00005), .TICK_CYCLES(TK)) u_rpo_retransmit (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .input_a_i(input_a_i), .input_b_i(input_b_i),
        .total_inc_i(total_inc_i), .total_reset_i(total_reset_i), .count_function_i(count_function_i),
        .pulse_output_on_i(pulse_output_on_i), .pulse_origin_select_i(pulse_origin_select_i),
        .rate_divisor_i(rate_divisor_i), .pulse_length_select_i(pulse_length_select_i),
        .prog_button_i(prog_button_i), .enter_button_i(enter_button_i), .up_button_i(up_button_i),
        .down_button_i(down_button_i), .menu_exit_i(menu_exit_i), .pulse_switch_closed_o(pulse_switch_closed_o),
        .retransmit_indicator_o(retransmit_indicator_o), .quad_step_o(quad_step_o), .quad_up_o(quad_up_o),
        .config_mode_o(config_mode_o), .menu_timeout_o(menu_timeout_o));
    rpo_remote_counter u_rpo_remote_counter (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .switch_closed_i(pulse_switch_closed_o), .line_o(line), .pulse_count_o(pulse_count), .last_len_o(last_len));
    always #50 sys_clk_i = ~sys_clk_i;
    // ceiling sized for the whole run, the width and divisor sweeps included, plus margin
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 95000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #10;
    endtask : step
    task automatic check_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit
    task automatic check_num(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            fail_count++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_num
    task automatic incs(input int n);
        total_inc_i = 1'b1;
        step(n);
        total_inc_i = 1'b0;
    endtask : incs
    task automatic wait_count(input int n, input int bound);
        for (int i = 0; i < bound && pulse_count < n; i++) step(1);
    endtask : wait_count
    task automatic t_pass();
        rate_divisor_i = 3'h4;
        pulse_length_select_i = 4'hA;
        for (int o = 0; o < 2; o++) begin
            pulse_origin_select_i = rpo_origin_t'(o);
            for (int v = 0; v < 4; v++) begin
                input_a_i = v[0];
                input_b_i = v[1];
                step(1);
                check_bit("copy", o ? v[1] : v[0], pulse_switch_closed_o);
                check_bit("indicator", 1'b1, retransmit_indicator_o);
            end
            pulse_output_on_i = 1'b0;
            step(1);
            check_bit("disabled", 1'b0, pulse_switch_closed_o);
            pulse_output_on_i = 1'b1;
            step(1);
            check_bit("enabled", 1'b1, pulse_switch_closed_o);
        end
        pulse_origin_select_i = rpo_origin_t'(2'h3);
        input_a_i = 1'b1;
        step(1);
        check_bit("open origin", 1'b0, pulse_switch_closed_o);
        check_bit("open indicator", 1'b1, retransmit_indicator_o);
        input_a_i = 1'b0;
        input_b_i = 1'b0;
        pulse_length_select_i = 4'h0;
        pulse_origin_select_i = RPO_COUNT_DERIVED;
        step(20);
    endtask : t_pass
    task automatic t_divisor();
        int base;
        for (int d = 0; d < 5; d++) begin
            rate_divisor_i = 3'(d);
            base = pulse_count;
            if (divs[d] > 1) incs(divs[d] - 1);
            step(12);
            check_num("early pulses", base, pulse_count);
            incs(1);
            wait_count(base + 1, 20);
            check_num("divided pulses", base + 1, pulse_count);
        end
    endtask : t_divisor
    task automatic t_width();
        int base;
        rate_divisor_i = 3'h0;
        for (int w = 0; w < 11; w++) begin
            pulse_length_select_i = 4'(w);
            base = pulse_count;
            incs(1);
            wait_count(base + 1, 2 * ticks[w] * TK + 10);
            check_num("width", ticks[w] * TK, last_len);
            step(ticks[w] * TK + 2);
        end
        pulse_length_select_i = 4'h0;
    endtask : t_width
    task automatic t_queue();
        int base;
        base = pulse_count;
        // six increments back to back outrun 4-cycle pulses with 4-cycle gaps, so five must queue
        incs(6);
        wait_count(base + 6, 44);
        check_num("queued burst", base + 6, pulse_count);
        base = pulse_count;
        pulse_output_on_i = 1'b0;
        incs(1);
        step(12);
        pulse_output_on_i = 1'b1;
        check_num("suppressed", base, pulse_count);
        count_function_i = RPO_FN_DIFF;
        base = pulse_count;
        incs(5);
        input_a_i = 1'b1;
        count_function_i = RPO_FN_QUAD;
        step(1);
        check_bit("quad step", 1'b1, quad_step_o);
        check_bit("quad up", 1'b1, quad_up_o);
        input_b_i = 1'b1;
        step(1);
        check_bit("quad up", 1'b1, quad_up_o);
        input_a_i = 1'b0;
        step(1);
        input_b_i = 1'b0;
        step(2);
        check_bit("quad idle", 1'b0, quad_step_o);
        input_b_i = 1'b1;
        step(1);
        check_bit("quad down", 1'b0, quad_up_o);
        input_b_i = 1'b0;
        step(20);
        check_num("not sum", base, pulse_count);
        count_function_i = RPO_FN_SUM;
    endtask : t_queue
    task automatic t_clear();
        int base;
        base = pulse_count;
        pulse_length_select_i = 4'h2;
        incs(5);
        step(5);
        total_reset_i = 1'b1;
        step(3);
        total_reset_i = 1'b0;
        step(500);
        check_num("after clear", base + 1, pulse_count);
        pulse_length_select_i = 4'h0;
    endtask : t_clear
    task automatic t_menu();
        int i;
        prog_button_i = 1'b1;
        enter_button_i = 1'b1;
        step(1);
        check_bit("menu", 1'b1, config_mode_o);
        prog_button_i = 1'b0;
        enter_button_i = 1'b0;
        step(10);
        up_button_i = 1'b1;
        step(1);
        up_button_i = 1'b0;
        for (i = 0; i < 40 && menu_timeout_o !== 1'b1; i++) step(1);
        check_bit("timeout", 1'b1, menu_timeout_o);
        check_bit("restart", 1'b1, i >= 15);
        check_bit("menu left", 1'b0, config_mode_o);
        prog_button_i = 1'b1;
        enter_button_i = 1'b1;
        step(1);
        prog_button_i = 1'b0;
        enter_button_i = 1'b0;
        menu_exit_i = 1'b1;
        step(1);
        menu_exit_i = 1'b0;
        check_bit("menu exit", 1'b0, config_mode_o);
        check_bit("exit quiet", 1'b0, menu_timeout_o);
    endtask : t_menu
    task automatic report_and_stop();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        step(20);
        reset_n_i = 1'b1;
        step(1);
        t_pass();
        t_divisor();
        t_width();
        t_queue();
        t_clear();
        t_menu();
        report_and_stop();
    end
endmodule : rpo_retransmit_tb_top
